// ---- rtl/receiver_setting_command_parser.v ----
// text setting command parser behind an avalon-mm slave
`timescale 1ns/10ps
`include "emi_cmd_regs.vh"
// Notes on behaviour
// - margin command takes -20..20 and stores it as smart margin in dB.
// - smart threshold sits margin dB below the level of the selected limit point.
// - limit point write carries index 0..15, frequency in Hz, level.
// - writing a point clears all stored points with higher index.
// - input select 0 is N connector, 1 line one, 2 line two.
// - input select above 2 is ignored with an error reply.
// - manual frequency sets tuning frequency and enters manual mode.
// - plain manual command always granted, enters manual mode.
// - manual with defaults enters manual mode and loads default settings.
// - attenuator 0..max sets value, disables auto, enters manual mode.
// - negative attenuator argument enables automatic attenuation.
// - hold time command sets hold in ms and enters manual mode.
// - bandwidth index 1..10 decodes to the listed bandwidths.
// - bandwidth index 0 is automatic; valid nonzero index disables it.
// - every command answered with its code plus ok or error.
// - name-and-activate checks point coherence before activating.
// - name-and-activate without a name deactivates the limit.
module receiver_setting_command_parser #(
   parameter NUM_W = 36,
   parameter [7:0] ATT_MAX = 8'h23,
   parameter [2:0] RBW_OPT_EN = 3'h7
) (
   input wire mclk,
   input wire srst,
   input wire [5:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   input wire [3:0] byteenable,
   output wire [31:0] readdata,
   output wire waitrequest,
   output wire manualMode,
   output wire [1:0] inputSel,
   output wire [7:0] marginDb,
   output wire [31:0] manualFreqHz,
   output wire [7:0] attenDb,
   output wire autoAtten,
   output wire [7:0] minAttenDb,
   output wire [31:0] holdTimeMs,
   output wire [3:0] rbwIndex,
   output wire autoRbw,
   output wire [31:0] rbwHz,
   output wire preselectorOn,
   output wire preampOn,
   output wire pulseLimiterOn,
   output wire trackingGenOn,
   output wire limitActive
);
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_MNEM = 3'h1;
   localparam [2:0] ST_ARGS = 3'h2;
   localparam [2:0] ST_WAIT = 3'h3;
   localparam [2:0] ST_EXEC = 3'h4;

   reg [2:0] state_q;
   reg waitReq_q;
   reg [31:0] readdata_q;
   reg [39:0] mnem_q;
   reg [2:0] mlen_q;
   reg sSeen_q, bad_q, hasDig_q, expMode_q, nameSeen_q, sepStar_q;
   reg [1:0] nf_q;
   reg signed [NUM_W-1:0] fld0_q, fld1_q, fld2_q;
   reg [3:0] replyCode_q;
   reg replyOk_q, replyNew_q;
   reg manual_q, autoAtt_q, autoRbw_q, presel_q, preamp_q, pulseLim_q;
   reg trackGen_q, limAct_q;
   reg [1:0] inputSel_q;
   reg [7:0] margin_q, atten_q, min_attenuation_q;
   reg [31:0] manFreq_q, hold_q, rbwHz_q;
   reg [3:0] rbwIdx_q, limSel_q;
   reg [15:0] limValid_q;
   reg [31:0] limFreq_q [0:15];
   reg [15:0] limLevel_q [0:15];
   reg [31:0] rdMux;

   // one-cycle answer, stretched while the parser digests a command
   wire busy = (state_q == ST_WAIT) || (state_q == ST_EXEC);
   wire take = (read || write) && waitReq_q && !busy;
   wire commitWr = write && !waitReq_q;
   wire commitRd = read && !waitReq_q;
   wire [7:0] ch = writedata[7:0];
   wire charStb = commitWr && (address == `REG_CHAR) && byteenable[0];
   wire [7:0] up = ch & 8'hDF;
   wire isDigit = (ch >= `CH_ZERO) && (ch <= `CH_NINE);
   wire isLetter = (up >= `CH_UP_A) && (up <= `CH_UP_Z);
   wire isSep = (ch == `CH_COMMA) || (ch == `CH_SEMI) || (ch == `CH_STAR);
   wire isLie = (mnem_q == `MN_NAME_ACTIVATE_LIMIT);
   wire inArgs = (state_q == ST_ARGS) && !isLie;
   wire mnemToArg = (state_q == ST_MNEM) && (isDigit || ch == `CH_MINUS);
   wire argChar = charStb && (inArgs || mnemToArg);
   wire signed [NUM_W-1:0] accValue;
   wire accBusy, accOvf;
   wire accDig = argChar && isDigit && !expMode_q;
   wire accExp = argChar && isDigit && expMode_q;
   wire accNeg = argChar && (ch == `CH_MINUS) && !hasDig_q && !expMode_q;
   wire accStart = charStb && inArgs && isSep && hasDig_q;
   wire accClr = (charStb && ch == `CH_HASH)
                 || ((state_q == ST_WAIT) && !accBusy && !accStart);
   wire oneArg = !bad_q && (nf_q == 2'h1);
   wire f0Pos = (fld0_q >= 0);

   num_field_acc #(.W(NUM_W)) acc (
      .mclk(mclk),
      .srst(srst),
      .clear(accClr),
      .digitStb(accDig),
      .expStb(accExp),
      .negStb(accNeg),
      .digit(ch[3:0]),
      .start(accStart),
      .value(accValue),
      .busy(accBusy),
      .overflow(accOvf)
   );

   // points must start at index 0, be contiguous, and never fall in frequency
   wire [14:0] pairOk;
   wire [15:0] nextValid;
   genvar i;
   generate
      for (i = 0; i < 16; i = i + 1) begin : g_pt
         if (i < 15) begin : g_pair
            assign pairOk[i] = !limValid_q[i+1] || (limValid_q[i] &&
               (limFreq_q[i+1] >= limFreq_q[i]));
         end
         assign nextValid[i] = (i < fld0_q[3:0]) ? limValid_q[i]
                               : (i == fld0_q[3:0]);
      end
   endgenerate
   wire coherent = limValid_q[0] && (&pairOk);

   wire liwOk = !bad_q && (nf_q == 2'h3) && f0Pos
                && (fld0_q <= `LIM_IDX_MAX) && (fld1_q >= 0)
                && (fld1_q <= `U32_MAX) && (fld2_q >= `LEVEL_MIN)
                && (fld2_q <= `LEVEL_MAX);
   wire u32Ok = oneArg && f0Pos && (fld0_q <= `U32_MAX);
   wire rbwOpt = (fld0_q[3:0] == 4'h7) ? RBW_OPT_EN[0]
                 : (fld0_q[3:0] == 4'h8) ? RBW_OPT_EN[1]
                 : (fld0_q[3:0] == 4'h9) ? RBW_OPT_EN[2] : 1'b1;
   wire [16:0] thr = {limLevel_q[limSel_q][15], limLevel_q[limSel_q]}
                     - {{9{margin_q[7]}}, margin_q};

   function [31:0] rbwDecode;
      input [3:0] idx;
      begin
         case (idx)
            4'h1: rbwDecode = `RBW_HZ_1;
            4'h2: rbwDecode = `RBW_HZ_2;
            4'h3: rbwDecode = `RBW_HZ_3;
            4'h4: rbwDecode = `RBW_HZ_4;
            4'h5: rbwDecode = `RBW_HZ_5;
            4'h6: rbwDecode = `RBW_HZ_6;
            4'h7: rbwDecode = `RBW_HZ_7;
            4'h8: rbwDecode = `RBW_HZ_8;
            4'h9: rbwDecode = `RBW_HZ_9;
            4'hA: rbwDecode = `RBW_HZ_10;
            default: rbwDecode = `RST_RBW_HZ;
         endcase
      end
   endfunction

   always @* begin
      case (address)
         `REG_REPLY: rdMux = {23'h000000, replyNew_q, 3'h0, replyOk_q,
                              replyCode_q};
         `REG_STATUS: rdMux = {17'h00000, busy, rbwIdx_q, limAct_q,
                               trackGen_q, pulseLim_q, preamp_q, presel_q,
                               autoRbw_q, autoAtt_q, inputSel_q, manual_q};
         `REG_MARGIN: rdMux = {{24{margin_q[7]}}, margin_q};
         `REG_MANFREQ: rdMux = manFreq_q;
         `REG_ATTEN: rdMux = {16'h0000, min_attenuation_q, atten_q};
         `REG_HOLD: rdMux = hold_q;
         `REG_RBWHZ: rdMux = rbwHz_q;
         `REG_LIMSEL: rdMux = {28'h0000000, limSel_q};
         `REG_LIMFREQ: rdMux = limFreq_q[limSel_q];
         `REG_LIMLEVEL: rdMux = {{16{limLevel_q[limSel_q][15]}},
                                 limLevel_q[limSel_q]};
         `REG_LIMTHR: rdMux = {{15{thr[16]}}, thr};
         `REG_LIMVALID: rdMux = {16'h0000, limValid_q};
         default: rdMux = 32'h00000000;
      endcase
   end

   always @(posedge mclk) begin
      if (srst) begin
         waitReq_q <= 1'b1;
         readdata_q <= 32'h00000000;
         limSel_q <= 4'h0;
      end else begin
         waitReq_q <= !take;
         if (take) readdata_q <= rdMux;
         if (commitWr && address == `REG_LIMSEL && byteenable[0])
            limSel_q <= writedata[3:0];
      end
   end

   always @(posedge mclk) begin
      if (srst) begin
         state_q <= ST_IDLE;
         mnem_q <= 40'h0000000000;
         mlen_q <= 3'h0;
         {sSeen_q, bad_q, hasDig_q, expMode_q, nameSeen_q} <= 5'h00;
         sepStar_q <= 1'b0;
         nf_q <= 2'h0;
         fld0_q <= {NUM_W{1'b0}};
         fld1_q <= {NUM_W{1'b0}};
         fld2_q <= {NUM_W{1'b0}};
      end else begin
         if (charStb && ch == `CH_HASH) begin
            state_q <= ST_MNEM;
            mnem_q <= 40'h0000000000;
            mlen_q <= 3'h0;
            {sSeen_q, bad_q, hasDig_q, expMode_q, nameSeen_q} <= 5'h00;
            nf_q <= 2'h0;
         end else begin
            case (state_q)
               ST_IDLE: state_q <= ST_IDLE;
               ST_MNEM: if (charStb) begin
                  if (isLetter && !sSeen_q) begin
                     sSeen_q <= 1'b1;
                     if (up != `CH_UP_S) bad_q <= 1'b1;
                  end else if (isLetter) begin
                     mnem_q <= {mnem_q[31:0], up};
                     mlen_q <= mlen_q + 3'h1;
                     if (mlen_q == 3'h5) bad_q <= 1'b1;
                  end else if (ch == `CH_STAR) begin
                     state_q <= ST_EXEC;
                  end else if (mnemToArg) begin
                     state_q <= ST_ARGS;
                     hasDig_q <= isDigit;
                  end else if (ch == `CH_SPACE) begin
                     if (mlen_q >= 3'h3) state_q <= ST_ARGS;
                  end else begin
                     bad_q <= 1'b1;
                  end
               end
               ST_ARGS: if (charStb) begin
                  if (isLie) begin
                     if (ch == `CH_STAR) state_q <= ST_EXEC;
                     else if (ch != `CH_SPACE) nameSeen_q <= 1'b1;
                  end else if (isDigit) begin
                     hasDig_q <= 1'b1;
                  end else if (ch == `CH_MINUS) begin
                     if (hasDig_q || expMode_q) bad_q <= 1'b1;
                  end else if (up == `CH_UP_E) begin
                     if (!hasDig_q || expMode_q) bad_q <= 1'b1;
                     expMode_q <= 1'b1;
                  end else if (isSep) begin
                     sepStar_q <= (ch == `CH_STAR);
                     if (hasDig_q) state_q <= ST_WAIT;
                     else if (ch == `CH_STAR) state_q <= ST_EXEC;
                     if (!hasDig_q && (ch != `CH_STAR || nf_q != 2'h0))
                        bad_q <= 1'b1;
                  end else if (ch != `CH_SPACE && ch != `CH_PLUS) begin
                     bad_q <= 1'b1;
                  end
               end
               ST_WAIT: if (!accBusy && !accStart) begin
                  case (nf_q)
                     2'h0: fld0_q <= accValue;
                     2'h1: fld1_q <= accValue;
                     2'h2: fld2_q <= accValue;
                     default: bad_q <= 1'b1;
                  endcase
                  if (accOvf) bad_q <= 1'b1;
                  if (nf_q != 2'h3) nf_q <= nf_q + 2'h1;
                  hasDig_q <= 1'b0;
                  expMode_q <= 1'b0;
                  state_q <= sepStar_q ? ST_EXEC : ST_ARGS;
               end
               ST_EXEC: state_q <= ST_IDLE;
               default: state_q <= ST_IDLE;
            endcase
         end
      end
   end

   // settings change only on a granted command; all else keeps them
   always @(posedge mclk) begin
      if (srst) begin
         replyCode_q <= `RC_UNKNOWN;
         replyOk_q <= 1'b0;
         replyNew_q <= 1'b0;
         manual_q <= 1'b0;
         inputSel_q <= 2'h0;
         margin_q <= 8'h00;
         manFreq_q <= `RST_MAN_FREQ;
         atten_q <= `RST_ATTEN;
         autoAtt_q <= 1'b1;
         min_attenuation_q <= `DEF_MIN_ATT;
         hold_q <= `DEF_HOLD_MS;
         rbwIdx_q <= 4'h0;
         autoRbw_q <= 1'b1;
         rbwHz_q <= `RST_RBW_HZ;
         {presel_q, preamp_q, pulseLim_q, trackGen_q} <= 4'h8;
         limAct_q <= 1'b0;
         limValid_q <= 16'h0000;
      end else begin
         if (commitRd && address == `REG_REPLY) replyNew_q <= 1'b0;
         if (state_q == ST_EXEC) begin
            replyNew_q <= 1'b1;
            replyOk_q <= 1'b0;
            case (mnem_q)
               `MN_SET_MARGIN: begin
                  replyCode_q <= `RC_LIM;
                  if (oneArg && fld0_q >= `MARGIN_MIN
                      && fld0_q <= `MARGIN_MAX) begin
                     margin_q <= fld0_q[7:0];
                     replyOk_q <= 1'b1;
                  end
               end
               `MN_WRITE_LIMIT_POINT: begin
                  replyCode_q <= `RC_LIW;
                  if (liwOk) begin
                     limFreq_q[fld0_q[3:0]] <= fld1_q[31:0];
                     limLevel_q[fld0_q[3:0]] <= fld2_q[15:0];
                     limValid_q <= nextValid;
                     replyOk_q <= 1'b1;
                  end
               end
               `MN_NAME_ACTIVATE_LIMIT: begin
                  replyCode_q <= `RC_LIE;
                  if (!nameSeen_q) begin
                     limAct_q <= 1'b0;
                     replyOk_q <= 1'b1;
                  end else if (coherent) begin
                     limAct_q <= 1'b1;
                     replyOk_q <= 1'b1;
                  end
               end
               `MN_SELECT_INPUT: begin
                  replyCode_q <= `RC_LSN;
                  if (oneArg && f0Pos && fld0_q <= `INPUT_MAX) begin
                     inputSel_q <= fld0_q[1:0];
                     replyOk_q <= 1'b1;
                  end
               end
               `MN_SET_MANUAL_FREQ: begin
                  replyCode_q <= `RC_MAF;
                  if (u32Ok) begin
                     manFreq_q <= fld0_q[31:0];
                     manual_q <= 1'b1;
                     replyOk_q <= 1'b1;
                  end
               end
               `MN_ENTER_MANUAL: begin
                  replyCode_q <= `RC_MAN;
                  manual_q <= 1'b1;
                  replyOk_q <= 1'b1;
               end
               `MN_MANUAL_WITH_DEFAULTS: begin
                  replyCode_q <= `RC_MANP;
                  manual_q <= 1'b1;
                  replyOk_q <= 1'b1;
                  autoRbw_q <= 1'b1;
                  autoAtt_q <= 1'b1;
                  min_attenuation_q <= `DEF_MIN_ATT;
                  hold_q <= `DEF_HOLD_MS;
                  {presel_q, preamp_q, pulseLim_q, trackGen_q} <= 4'h8;
               end
               `MN_SET_ATTENUATOR: begin
                  replyCode_q <= `RC_MAT;
                  if (oneArg && !f0Pos) begin
                     autoAtt_q <= 1'b1;
                     manual_q <= 1'b1;
                     replyOk_q <= 1'b1;
                  end else if (oneArg && fld0_q <=
                               $signed({28'h0000000, ATT_MAX})) begin
                     atten_q <= fld0_q[7:0];
                     autoAtt_q <= 1'b0;
                     manual_q <= 1'b1;
                     replyOk_q <= 1'b1;
                  end
               end
               `MN_SET_HOLD_TIME: begin
                  replyCode_q <= `RC_MHT;
                  if (u32Ok) begin
                     hold_q <= fld0_q[31:0];
                     manual_q <= 1'b1;
                     replyOk_q <= 1'b1;
                  end
               end
               `MN_SET_RES_BANDWIDTH: begin
                  replyCode_q <= `RC_RBW;
                  if (oneArg && fld0_q == 0) begin
                     autoRbw_q <= 1'b1;
                     replyOk_q <= 1'b1;
                  end else if (oneArg && f0Pos && rbwOpt
                               && fld0_q <= `RBW_IDX_MAX) begin
                     rbwIdx_q <= fld0_q[3:0];
                     rbwHz_q <= rbwDecode(fld0_q[3:0]);
                     autoRbw_q <= 1'b0;
                     replyOk_q <= 1'b1;
                  end
               end
               default: replyCode_q <= `RC_UNKNOWN;
            endcase
         end
      end
   end

   assign readdata = readdata_q;
   assign waitrequest = waitReq_q;
   assign manualMode = manual_q;
   assign inputSel = inputSel_q;
   assign marginDb = margin_q;
   assign manualFreqHz = manFreq_q;
   assign attenDb = atten_q;
   assign autoAtten = autoAtt_q;
   assign minAttenDb = min_attenuation_q;
   assign holdTimeMs = hold_q;
   assign rbwIndex = rbwIdx_q;
   assign autoRbw = autoRbw_q;
   assign rbwHz = rbwHz_q;
   assign preselectorOn = presel_q;
   assign preampOn = preamp_q;
   assign pulseLimiterOn = pulseLim_q;
   assign trackingGenOn = trackGen_q;
   assign limitActive = limAct_q;
endmodule // receiver_setting_command_parser

// ---- rtl/emi_cmd_regs.vh ----
// register map, command codes and reset values of the setting parser
`ifndef EMI_CMD_REGS_VH
`define EMI_CMD_REGS_VH
`define REG_CHAR 6'h00
`define REG_REPLY 6'h04
`define REG_STATUS 6'h08
`define REG_MARGIN 6'h0C
`define REG_MANFREQ 6'h10
`define REG_ATTEN 6'h14
`define REG_HOLD 6'h18
`define REG_RBWHZ 6'h1C
`define REG_LIMSEL 6'h20
`define REG_LIMFREQ 6'h24
`define REG_LIMLEVEL 6'h28
`define REG_LIMTHR 6'h2C
`define REG_LIMVALID 6'h30
`define REPLY_OK_BIT 4
`define REPLY_NEW_BIT 8
`define RC_UNKNOWN 4'h0
`define RC_LIM 4'h1
`define RC_LIW 4'h2
`define RC_LIE 4'h3
`define RC_LSN 4'h4
`define RC_MAF 4'h5
`define RC_MAN 4'h6
`define RC_MANP 4'h7
`define RC_MAT 4'h8
`define RC_MHT 4'h9
`define RC_RBW 4'hA
`define MN_SET_MARGIN 40'h00004C494D
`define MN_WRITE_LIMIT_POINT 40'h00004C4957
`define MN_NAME_ACTIVATE_LIMIT 40'h00004C4945
`define MN_SELECT_INPUT 40'h00004C534E
`define MN_SET_MANUAL_FREQ 40'h00004D4146
`define MN_ENTER_MANUAL 40'h00004D414E
`define MN_MANUAL_WITH_DEFAULTS 40'h004D414E50
`define MN_SET_ATTENUATOR 40'h00004D4154
`define MN_SET_HOLD_TIME 40'h00004D4854
`define MN_SET_RES_BANDWIDTH 40'h0000524257
`define MARGIN_MIN (-36'sh14)
`define MARGIN_MAX 36'sh14
`define LIM_IDX_MAX 36'sh00F
`define INPUT_MAX 36'sh2
`define RBW_IDX_MAX 36'shA
`define U32_MAX 36'sh0FFFFFFFF
`define LEVEL_MIN (-36'sh8000)
`define LEVEL_MAX 36'sh7FFF
`define DEF_MIN_ATT 8'h0A
`define DEF_HOLD_MS 32'h000003E8
`define RST_ATTEN 8'h00
`define RST_MAN_FREQ 32'h00000000
`define RST_RBW_HZ 32'h00000000
`define RBW_HZ_1 32'h000493E0
`define RBW_HZ_2 32'h000186A0
`define RBW_HZ_3 32'h00007530
`define RBW_HZ_4 32'h00002710
`define RBW_HZ_5 32'h00000BB8
`define RBW_HZ_6 32'h00002328
`define RBW_HZ_7 32'h000000C8
`define RBW_HZ_8 32'h000003E8
`define RBW_HZ_9 32'h000F4240
`define RBW_HZ_10 32'h0001D4C0
`define CH_HASH 8'h23
`define CH_STAR 8'h2A
`define CH_SPACE 8'h20
`define CH_MINUS 8'h2D
`define CH_PLUS 8'h2B
`define CH_COMMA 8'h2C
`define CH_SEMI 8'h3B
`define CH_ZERO 8'h30
`define CH_NINE 8'h39
`define CH_UP_A 8'h41
`define CH_UP_Z 8'h5A
`define CH_UP_E 8'h45
`define CH_UP_S 8'h53
`endif

// ---- rtl/num_field_acc.v ----
// decimal argument accumulator with exponent scaling
`timescale 1ns/10ps
module num_field_acc #(
   parameter W = 36
) (
   input wire mclk,
   input wire srst,
   input wire clear,
   input wire digitStb,
   input wire expStb,
   input wire negStb,
   input wire [3:0] digit,
   input wire start,
   output wire signed [W-1:0] value,
   output wire busy,
   output wire overflow
);
   reg [W-1:0] mant_q;
   reg [4:0] exp_q;
   reg neg_q;
   reg busy_q;
   reg ovf_q;
   wire [W+3:0] mulTen = {1'b0, mant_q, 3'b000} + {3'b000, mant_q, 1'b0};
   wire [W+3:0] digSum = mulTen + {{W{1'b0}}, digit};
   wire [7:0] expTen = {exp_q, 3'b000} + {2'b00, exp_q, 1'b0};
   wire [7:0] expSum = expTen + {4'h0, digit};

   // top bit kept free so the negated value never wraps
   always @(posedge mclk) begin
      if (srst || clear) begin
         mant_q <= {W{1'b0}};
         exp_q <= 5'h00;
         neg_q <= 1'b0;
         busy_q <= 1'b0;
         ovf_q <= 1'b0;
      end else begin
         if (digitStb) begin
            mant_q <= digSum[W-1:0];
            if (|digSum[W+3:W-1]) ovf_q <= 1'b1;
         end
         if (expStb) begin
            exp_q <= expSum[4:0];
            if (|expSum[7:5]) ovf_q <= 1'b1;
         end
         if (negStb) neg_q <= 1'b1;
         if (start) busy_q <= 1'b1;
         else if (busy_q) begin
            if (exp_q != 5'h00) begin
               mant_q <= mulTen[W-1:0];
               exp_q <= exp_q - 5'h01;
               if (|mulTen[W+3:W-1]) ovf_q <= 1'b1;
            end else begin
               busy_q <= 1'b0;
            end
         end
      end
   end

   assign value = neg_q ? $signed(~mant_q + {{(W-1){1'b0}}, 1'b1})
                        : $signed(mant_q);
   assign busy = busy_q;
   assign overflow = ovf_q;
endmodule // num_field_acc

// ---- bench/parser_assertions.sv ----
// port-level checks of the setting command parser
`timescale 1ns/10ps
module parser_assertions #(
   parameter [7:0] ATT_MAX = 8'h23
) (
   input wire mclk,
   input wire srst,
   input wire waitrequest,
   input wire manualMode,
   input wire [1:0] inputSel,
   input wire [7:0] marginDb,
   input wire [7:0] attenDb,
   input wire autoAtten,
   input wire [31:0] holdTimeMs,
   input wire [3:0] rbwIndex,
   input wire [31:0] rbwHz
);
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   chk_wait_one_cycle: assert property (!waitrequest |=>
      waitrequest) else $error("waitrequest low two cycles");
   chk_margin_range: assert property (
      $signed(marginDb) >= -8'sd20 && $signed(marginDb) <= 8'sd20)
      else $error("margin out of range");
   chk_input_legal: assert property (inputSel != 2'h3)
      else $error("illegal input selection");
   chk_atten_max: assert property (!autoAtten |->
      attenDb <= ATT_MAX) else $error("attenuation above maximum");
   chk_atten_manual: assert property ($fell(autoAtten) |->
      ##[0:1] manualMode)
      else $error("fixed attenuation without manual mode");
   chk_manual_sticks: assert property ($fell(manualMode) |->
      $past(srst)) else $error("manual mode left without reset");
   chk_hold_manual: assert property ($changed(holdTimeMs) &&
      holdTimeMs != 32'h000003E8 |-> ##[0:1] manualMode)
      else $error("hold time set without manual mode");
   chk_rbw_decode: assert property (rbwIndex == 4'h3 |->
      rbwHz == 32'h00007530) else $error("bandwidth index 3 decoded wrongly");
endmodule // parser_assertions

// ---- bench/host_model.sv ----
// host model: avalon-mm master that types setting commands
`timescale 1ns/10ps
module host_model (
   input wire mclk,
   input wire [31:0] readdata,
   input wire waitrequest,
   output logic [5:0] address,
   output logic read,
   output logic write,
   output logic [31:0] writedata,
   output logic [3:0] byteenable
);
   initial begin
      address = 6'h00;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h00000000;
      byteenable = 4'hF;
   end
   // held until waitrequest is sampled low; one idle edge keeps strobes apart
   task automatic xfer(input logic w, input logic [5:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      address <= a;
      writedata <= d;
      write <= w;
      read <= !w;
      @(posedge mclk);
      while (waitrequest !== 1'b0) @(posedge mclk);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge mclk);
   endtask
   // one char per write, then poll until a fresh reply shows
   task automatic cmd(input string s, output logic [31:0] q);
      for (int i = 0; i < s.len(); i++)
         xfer(1'b1, 6'h00, {24'h000000, s[i]}, q);
      q = 32'h00000000;
      while (q[8] !== 1'b1) xfer(1'b0, 6'h04, 32'h00000000, q);
   endtask
endmodule // host_model

// ---- bench/testbench.sv ----
// self-checking bench for the setting command parser
`timescale 1ns/10ps
`define CHK(got, exp) begin samplesChecked++; if ((got) !== (exp)) begin \
   nMismatch++; $display("unexpected at %0t got %h exp %h", $time, got, exp); \
   end end
module testbench;
   logic mclk;
   logic srst = 1'b1;
   int nMismatch = 0;
   int samplesChecked = 0;
   int cycles = 0;
   int hzTab[10] = '{300000, 100000, 30000, 10000, 3000, 9000, 200, 1000,
                     1000000, 120000};
   wire [5:0] address;
   wire [3:0] byteenable, rbwIndex;
   wire [31:0] writedata, readdata, manualFreqHz, holdTimeMs, rbwHz;
   wire [7:0] marginDb, attenDb, minAttenDb;
   wire [1:0] inputSel;
   wire read, write, waitrequest, manualMode, autoAtten, autoRbw;
   wire preselectorOn, preampOn, pulseLimiterOn, trackingGenOn, limitActive;
   receiver_setting_command_parser uut (.mclk, .srst, .address, .read, .write,
      .writedata, .byteenable, .readdata, .waitrequest, .manualMode, .inputSel,
      .marginDb, .manualFreqHz, .attenDb, .autoAtten, .minAttenDb, .holdTimeMs,
      .rbwIndex, .autoRbw, .rbwHz, .preselectorOn, .preampOn, .pulseLimiterOn,
      .trackingGenOn, .limitActive);
   host_model host (.mclk, .readdata, .waitrequest, .address, .read, .write,
      .writedata, .byteenable);
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic stopTest;
      $display("mismatches %0d checks %0d", nMismatch, samplesChecked);
      if (nMismatch == 0 && samplesChecked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic run(input string s, input logic [3:0] code, input logic ok);
      logic [31:0] q;
      host.cmd({"#S", s, "*"}, q);
      `CHK(q[4:0], {ok, code})
   endtask
   // all commands together run under two thousand cycles; the ceiling of 40000 leaves wide margin
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         nMismatch++;
         stopTest();
      end
   end
   initial begin
      int v, m, s, at;
      logic aA, aR, ok;
      logic [31:0] q, seed, hz;
      m = 0;
      s = 0;
      at = 0;
      aA = 1'b1;
      aR = 1'b1;
      hz = 32'h00000000;
      seed = 32'h1EA38493;
      repeat (20) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      for (int i = 0; i < 10; i++) begin
         seed = lfsr(seed);
         v = i == 0 ? 20 : i == 1 ? -21 : int'(seed[5:0]) - 30;
         ok = v >= -20 && v <= 20;
         if (ok) m = v;
         run($sformatf("LIM %0d", v), 4'h1, ok);
         `CHK(marginDb, m[7:0])
      end
      for (int i = 0; i < 5; i++) begin
         if (i <= 2) s = i;
         run($sformatf("LSN %0d", i), 4'h4, i <= 2);
         `CHK(inputSel, s[1:0])
      end
      for (int i = 0; i < 12; i++) begin
         if (i == 0) aR = 1'b1;
         else if (i <= 10) aR = 1'b0;
         if (i >= 1 && i <= 10) hz = hzTab[i - 1];
         run($sformatf("RBW %0d", i), 4'hA, i <= 10);
         `CHK({autoRbw, rbwHz}, {aR, hz})
         `CHK(rbwIndex, 4'(i > 10 ? 10 : i))
      end
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         v = i == 0 ? 36 : i == 1 ? 35 : int'(seed[5:0]) % 48 - 4;
         if (v >= 0 && v <= 35) at = v;
         if (v <= 35) aA = v < 0;
         run($sformatf("MAT %0d", v), 4'h8, v <= 35);
         `CHK({autoAtten, attenDb}, {aA, at[7:0]})
         if (i == 0) `CHK(manualMode, 1'b0)
      end
      run("MHT 15e2", 4'h9, 1'b1);
      `CHK(holdTimeMs, 32'h000005DC)
      run("MAF150e3", 4'h5, 1'b1);
      `CHK(manualFreqHz, 32'h000249F0)
      run("MANP", 4'h7, 1'b1);
      `CHK({manualMode, autoRbw, autoAtten}, 3'h7)
      `CHK({minAttenDb, holdTimeMs}, {8'h0A, 32'h000003E8})
      `CHK({preselectorOn, preampOn}, 2'h2)
      `CHK({pulseLimiterOn, trackingGenOn}, 2'h0)
      run("MAN", 4'h6, 1'b1);
      run("LIW 16, 1e3; 1", 4'h2, 1'b0);
      run("LIW 0, 150e3; 66", 4'h2, 1'b1);
      run("LIW 1, 500e3; 56", 4'h2, 1'b1);
      run("LIW 2, 5e6; 56", 4'h2, 1'b1);
      run("LIE Custom", 4'h3, 1'b1);
      `CHK(limitActive, 1'b1)
      host.xfer(1'b1, 6'h20, 32'h00000000, q);
      host.xfer(1'b0, 6'h2C, 32'h00000000, q);
      `CHK(q, 32'(66 - m))
      run("LIE", 4'h3, 1'b1);
      `CHK(limitActive, 1'b0)
      run("LIW 0, 1e3; 40", 4'h2, 1'b1);
      host.xfer(1'b0, 6'h30, 32'h00000000, q);
      `CHK(q[15:0], 16'h0001)
      run("LIW 2, 9e3; 40", 4'h2, 1'b1);
      run("LIE Bad", 4'h3, 1'b0);
      `CHK(limitActive, 1'b0)
      host.xfer(1'b0, 6'h3C, 32'h00000000, q);
      `CHK(q, 32'h00000000)
      stopTest();
   end
endmodule // testbench
bind receiver_setting_command_parser parser_assertions #(.ATT_MAX(ATT_MAX)) chk (
   .mclk, .srst, .waitrequest, .manualMode, .inputSel, .marginDb, .attenDb,
   .autoAtten, .holdTimeMs, .rbwIndex, .rbwHz);
